/* File: bench/serial_peer.sv */
`timescale 1ns/10ps
module serial_peer (
	input  wire logic ref_clk,
	output logic      rx_in
);
	// A cleared divisor runs as one, so one bit lasts sixteen clock cycles.
	localparam int BIT_CYCLES = 16;

	initial rx_in = 1'b1;

	// The line is left at the stop level, so the receiver never sees a false start between frames.
	task automatic send(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_in <= frame[i];
			repeat (BIT_CYCLES) @(posedge ref_clk);
		end
	endtask
endmodule

/* File: bench/uart_channel_reset_rx_unload_test.sv */
`timescale 1ns/10ps
module uart_channel_reset_rx_unload_test;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [9:0]  bus_addr = 10'h000;
	logic        bus_rd = 1'b0;
	logic        bus_wr = 1'b0;
	logic [7:0]  bus_wdata = 8'h00;
	logic [15:0] bus_rdata;
	logic        bus_rvalid;
	logic        rx_in;
	logic [3:0]  modem_in = 4'h0;
	logic        ir_pin = 1'b0;
	logic        tx_out, rts_n_out, dtr_n_out, irq_out, ee_clk, ee_sel, ee_dat;
	int          fail_count = 0;
	int          check_count = 0;
	logic [7:0]  q[$];
	logic [15:0] d;
	logic [9:0]  ra[15];
	logic [7:0]  rv[15];
	int          trig;
	logic [7:0]  b;

	always #12.5 ref_clk = ~ref_clk;

	serial_peer peer (.ref_clk(ref_clk), .rx_in(rx_in));

	uart_channel uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .bus_addr(bus_addr),
		.bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.bus_rvalid(bus_rvalid), .rx_in(rx_in), .cts_in(modem_in[0]), .dsr_in(modem_in[1]),
		.ri_in(modem_in[2]), .cd_in(modem_in[3]), .infrared_enable_pin(ir_pin), .tx_out(tx_out),
		.rts_n_out(rts_n_out), .dtr_n_out(dtr_n_out), .irq_out(irq_out), .eeprom_clock_out(ee_clk),
		.eeprom_select_out(ee_sel), .eeprom_data_out(ee_dat));

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic do_reset();
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, output logic [15:0] v);
		@(posedge ref_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		#1;
		v = bus_rdata;
		chk("rvalid", {15'h0, bus_rvalid}, 16'h0001);
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		bus_addr <= a;
		bus_wdata <= v;
		bus_wr <= 1'b1;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
	endtask

	task automatic send_rand(input int n);
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			q.push_back(b);
			peer.send(b);
		end
	endtask

	// Polls the level counter rather than waiting a fixed time, since the receive latency is not pinned.
	task automatic wait_level(input int n);
		for (int i = 0; i < 300; i++) begin
			rd(uart_pkg::ADDR_RXLVL, d);
			if (d[7:0] == 8'(n))
				break;
		end
		chk("rx_level", {8'h00, d[7:0]}, {8'h00, 8'(n)});
		repeat (2) @(posedge ref_clk);
	endtask

	task automatic pop_check(input logic [7:0] exp);
		rd(uart_pkg::ADDR_WINDOW, d);
		chk("window", d, {uart_pkg::RST_LSR | 8'h01, exp});
	endtask

	initial begin
		repeat (30000) @(posedge ref_clk);
		fail_count++;
		test_done();
	end

	initial begin
		void'($urandom(32'h3eff));
		modem_in = 4'($urandom);
		ra = '{uart_pkg::ADDR_IER, uart_pkg::ADDR_ISR, uart_pkg::ADDR_LCR, uart_pkg::ADDR_MCR,
			uart_pkg::ADDR_LSR, uart_pkg::ADDR_SCR, uart_pkg::ADDR_FEATURE_CONTROL, uart_pkg::ADDR_EFR,
			uart_pkg::ADDR_TXLVL, uart_pkg::ADDR_RXLVL, uart_pkg::ADDR_FLOW_CHAR_STATUS, uart_pkg::ADDR_FLOW,
			10'h011, 10'h012, 10'h013};
		rv = '{8'h00, uart_pkg::RST_ISR, 8'h00, 8'h00, uart_pkg::RST_LSR, uart_pkg::RST_SCR,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		do_reset();
		chk("pins", {tx_out, rts_n_out, dtr_n_out, ee_clk, ee_sel, ee_dat}, 16'h0038);
		for (int i = 0; i < 15; i++) begin
			rd(ra[i], d);
			chk("reset_value", {8'h00, d[7:0]}, {8'h00, rv[i]});
		end
		rd(uart_pkg::ADDR_MSR, d);
		chk("modem_status", {8'h00, d[7:0]}, {8'h00, modem_in[3], modem_in[2], modem_in[1], modem_in[0], 4'h0});
		rd(uart_pkg::ADDR_IDENT, d);
		chk("ident_byte", {8'h00, d[7:0]}, {8'h00, uart_pkg::IDENT_VALUE});
		rd(uart_pkg::ADDR_IDENT_DW, d);
		chk("ident_dword", {8'h00, d[15:8]}, {8'h00, uart_pkg::IDENT_VALUE});
		rd(uart_pkg::ADDR_GIRQ2, d);
		chk("girq2", d, 16'h0000);
		rd(uart_pkg::ADDR_GIRQ3, d);
		chk("girq3", d, 16'h0000);
		rd(10'h3ff, d);
		chk("unmapped", d, 16'h0000);
		trig = 2 + ($urandom % 4);
		wr(uart_pkg::ADDR_IER, 8'h01);
		wr(uart_pkg::ADDR_RXLVL, 8'(trig));
		send_rand(trig - 1);
		wait_level(trig - 1);
		chk("irq_below", {15'h0, irq_out}, 16'h0000);
		send_rand(1);
		wait_level(trig);
		chk("irq_at", {15'h0, irq_out}, 16'h0001);
		rd(uart_pkg::ADDR_GIRQ0, d);
		chk("girq0", {15'h0, d[0]}, 16'h0001);
		rd(uart_pkg::ADDR_GIRQ1, d);
		chk("girq1", {13'h0, d[2:0]}, {13'h0, uart_pkg::ISR_RX[3:1]});
		rd(uart_pkg::ADDR_ISR, d);
		chk("irq_status", {8'h00, d[7:0]}, {8'h00, uart_pkg::ISR_RX});
		rd(uart_pkg::ADDR_IDENT, d);
		while (q.size() > 0)
			pop_check(q.pop_front());
		rd(uart_pkg::ADDR_WINDOW, d);
		chk("empty", {15'h0, d[8]}, 16'h0000);
		repeat (2) @(posedge ref_clk);
		chk("irq_clear", {15'h0, irq_out}, 16'h0000);
		wr(uart_pkg::ADDR_RXLVL, uart_pkg::TRIG_MAX + 8'h01 + 8'($urandom % 190));
		send_rand(2);
		wait_level(2);
		chk("irq_high_trig", {15'h0, irq_out}, 16'h0000);
		rd(uart_pkg::ADDR_IDENT, d);
		pop_check(q.pop_front());
		b = 8'($urandom);
		wr(uart_pkg::ADDR_SCR, b);
		pop_check(q[0]);
		pop_check(q[0]);
		rd(uart_pkg::ADDR_IDENT, d);
		pop_check(q.pop_front());
		rd(uart_pkg::ADDR_WINDOW, d);
		chk("empty2", {15'h0, d[8]}, 16'h0000);
		rd(uart_pkg::ADDR_SCR, d);
		chk("scratch", {8'h00, d[7:0]}, {8'h00, b});
		ir_pin <= 1'b1;
		do_reset();
		chk("pins_ir", {tx_out, rts_n_out, dtr_n_out, ee_clk, ee_sel, ee_dat}, 16'h0018);
		test_done();
	end
endmodule

/* File: logic/sync_fifo.sv */
`timescale 1ns/10ps
module sync_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       ce,
	input  wire logic                       flush,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic      [WIDTH-1:0]           out_data,
	output logic      [$clog2(DEPTH):0]     level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      level_reg;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = level_reg != (AW+1)'(DEPTH);
	assign out_valid = level_reg != '0;
	assign out_data  = mem[rd_ptr_reg];
	assign level     = level_reg;

	always_ff @(posedge clk) begin
		if (ce && push && !flush) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			level_reg  <= '0;
		end else if (ce) begin
			if (flush) begin
				wr_ptr_reg <= '0;
				rd_ptr_reg <= '0;
				level_reg  <= '0;
			end else begin
				wr_ptr_reg <= push ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
				rd_ptr_reg <= pop ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
				level_reg  <= level_reg + (AW+1)'(push) - (AW+1)'(pop);
			end
		end
	end
endmodule

/* File: logic/uart_channel.sv */
`timescale 1ns/10ps
module uart_channel (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic [9:0]  bus_addr,
	input  wire logic        bus_rd,
	input  wire logic        bus_wr,
	input  wire logic [7:0]  bus_wdata,
	output logic      [15:0] bus_rdata,
	output logic             bus_rvalid,
	input  wire logic        rx_in,
	input  wire logic        cts_in,
	input  wire logic        dsr_in,
	input  wire logic        ri_in,
	input  wire logic        cd_in,
	input  wire logic        infrared_enable_pin,
	output logic             tx_out,
	output logic             rts_n_out,
	output logic             dtr_n_out,
	output logic             irq_out,
	output logic             eeprom_clock_out,
	output logic             eeprom_select_out,
	output logic             eeprom_data_out
);
	function automatic logic hit(input logic [9:0] a, input logic [9:0] b);
		return a == b;
	endfunction

	logic [7:0]  ier_reg, lcr_reg, mcr_reg, scr_reg, feature_control_reg, efr_reg, fcr_reg;
	logic [7:0]  dll_reg, dlm_reg, thr_reg, trig_reg, tx_trigger_level_reg, isr_reg;
	logic [7:0]  flow_reg [4];
	logic [2:0]  eeprom_reg;
	logic [3:0]  delta_reg, modem_prev;
	logic        overrun_reg, thr_full_reg, armed_reg, irq_reg;
	logic [15:0] rdata_reg, baud_cnt_reg;
	logic        rvalid_reg;

	// Register decode.
	wire dlab      = lcr_reg[uart_pkg::LCR_DLAB];
	wire acc       = clk_en && (bus_rd || bus_wr);
	wire wr        = clk_en && bus_wr;
	wire rd        = clk_en && bus_rd;
	wire wr_thr    = wr && hit(bus_addr, uart_pkg::ADDR_HOLD) && !dlab;
	wire wr_dll    = wr && hit(bus_addr, uart_pkg::ADDR_HOLD) && dlab;
	wire wr_dlm    = wr && hit(bus_addr, uart_pkg::ADDR_IER) && dlab;
	wire wr_ier    = wr && hit(bus_addr, uart_pkg::ADDR_IER) && !dlab;
	wire wr_fcr    = wr && hit(bus_addr, uart_pkg::ADDR_ISR);
	wire wr_trig   = wr && hit(bus_addr, uart_pkg::ADDR_RXLVL);
	wire is_ident  = hit(bus_addr, uart_pkg::ADDR_IDENT) || hit(bus_addr, uart_pkg::ADDR_IDENT_DW);
	wire is_window = hit(bus_addr, uart_pkg::ADDR_WINDOW);
	wire rd_lsr    = rd && hit(bus_addr, uart_pkg::ADDR_LSR);
	wire rd_msr    = rd && hit(bus_addr, uart_pkg::ADDR_MSR);

	// Receive FIFO.
	logic                              rx_push, fifo_in_ready, fifo_out_valid;
	logic [uart_pkg::FIFO_WIDTH-1:0]   rx_word, fifo_head;
	logic [$clog2(uart_pkg::FIFO_DEPTH):0] rx_level;
	wire rd_rhr = rd && hit(bus_addr, uart_pkg::ADDR_HOLD) && !dlab;
	wire rd_win = rd && is_window && armed_reg;
	wire rx_pop = (rd_rhr || rd_win) && fifo_out_valid;
	wire rx_flush = wr_fcr && bus_wdata[uart_pkg::FCR_RX_FLUSH];

	sync_fifo #(
		.WIDTH (uart_pkg::FIFO_WIDTH),
		.DEPTH (uart_pkg::FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (ref_clk),
		.rst       (sys_rst),
		.ce        (clk_en),
		.flush     (rx_flush),
		.in_valid  (rx_push),
		.in_ready  (fifo_in_ready),
		.in_data   (rx_word),
		.out_valid (fifo_out_valid),
		.out_ready (rx_pop),
		.out_data  (fifo_head),
		.level     (rx_level)
	);

	uart_pkg::line_state_t rx_state_reg, tx_state_reg;
	wire        tx_idle   = tx_state_reg == uart_pkg::LN_IDLE;

	// Status of the byte at the head of the FIFO plus overrun and transmitter state, in line status layout.
	wire [7:0] lsr_now = {1'b0, !thr_full_reg && tx_idle, !thr_full_reg, fifo_out_valid && fifo_head[9],
		fifo_out_valid && fifo_head[8], 1'b0, overrun_reg, fifo_out_valid};
	wire [7:0] rx_level8  = 8'(rx_level);
	wire [7:0] trig_eff   = (trig_reg == 8'h00) ? 8'h01 : trig_reg;
	wire       rx_at_trig = rx_level8 >= trig_eff;
	wire       line_irq   = ier_reg[2] && (overrun_reg || lsr_now[3] || lsr_now[4]);
	wire       rx_irq     = ier_reg[0] && rx_at_trig;
	wire       tx_irq     = ier_reg[1] && !thr_full_reg;
	wire       modem_irq  = ier_reg[3] && (delta_reg != 4'h0);
	wire [7:0] isr_next   = line_irq ? uart_pkg::ISR_LINE : rx_irq ? uart_pkg::ISR_RX :
		tx_irq ? uart_pkg::ISR_TX : modem_irq ? uart_pkg::ISR_MODEM : uart_pkg::RST_ISR;
	wire [3:0] modem_now  = {cd_in, ri_in, dsr_in, cts_in};

	// Baud tick at sixteen times the bit rate; a zero divisor acts as one.
	wire [15:0] div_raw   = {dlm_reg, dll_reg};
	wire [15:0] div_eff   = (div_raw == 16'h0000) ? 16'h0001 : div_raw;
	wire        tick      = clk_en && (baud_cnt_reg == div_eff - 16'h0001);

	// Receiver, fixed at eight data bits and one stop bit.
	logic [3:0] rx_os_reg, tx_os_reg;
	logic [2:0] rx_idx_reg, tx_idx_reg;
	logic [7:0] rx_sh_reg, tx_sh_reg;
	logic       tx_bit_reg;
	wire        rx_stop_end = tick && rx_state_reg == uart_pkg::LN_STOP && rx_os_reg == uart_pkg::OS_LAST;
	assign rx_push = rx_stop_end;
	assign rx_word = {!rx_in && rx_sh_reg == 8'h00, !rx_in, rx_sh_reg};

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			baud_cnt_reg <= 16'h0000;
		end else if (clk_en) begin
			baud_cnt_reg <= tick ? 16'h0000 : baud_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_state_reg <= uart_pkg::LN_IDLE;
			rx_os_reg    <= 4'h0;
			rx_idx_reg   <= 3'h0;
			rx_sh_reg    <= 8'h00;
		end else if (tick) begin
			rx_os_reg <= rx_os_reg + 4'h1;
			case (rx_state_reg)
				uart_pkg::LN_IDLE: begin
					rx_os_reg <= 4'h0;
					if (!rx_in) begin
						rx_state_reg <= uart_pkg::LN_START;
					end
				end
				uart_pkg::LN_START: begin
					// Re-check the start bit at mid-bit to reject glitches.
					if (rx_os_reg == uart_pkg::OS_MID) begin
						rx_os_reg    <= 4'h0;
						rx_idx_reg   <= 3'h0;
						rx_state_reg <= rx_in ? uart_pkg::LN_IDLE : uart_pkg::LN_DATA;
					end
				end
				uart_pkg::LN_DATA: begin
					if (rx_os_reg == uart_pkg::OS_LAST) begin
						rx_sh_reg  <= {rx_in, rx_sh_reg[7:1]};
						rx_idx_reg <= rx_idx_reg + 3'h1;
						if (rx_idx_reg == 3'h7) begin
							rx_state_reg <= uart_pkg::LN_STOP;
						end
					end
				end
				uart_pkg::LN_STOP: begin
					if (rx_os_reg == uart_pkg::OS_LAST) begin
						rx_state_reg <= uart_pkg::LN_IDLE;
					end
				end
				default: rx_state_reg <= uart_pkg::LN_IDLE;
			endcase
		end
	end

	// Transmitter with a one-byte holding register.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_state_reg <= uart_pkg::LN_IDLE;
			tx_os_reg    <= 4'h0;
			tx_idx_reg   <= 3'h0;
			tx_sh_reg    <= 8'h00;
			tx_bit_reg   <= 1'b1;
		end else if (tick) begin
			tx_os_reg <= tx_os_reg + 4'h1;
			case (tx_state_reg)
				uart_pkg::LN_IDLE: begin
					tx_os_reg <= 4'h0;
					if (thr_full_reg) begin
						tx_sh_reg    <= thr_reg;
						tx_bit_reg   <= 1'b0;
						tx_state_reg <= uart_pkg::LN_START;
					end
				end
				uart_pkg::LN_START: begin
					if (tx_os_reg == uart_pkg::OS_LAST) begin
						tx_bit_reg   <= tx_sh_reg[0];
						tx_idx_reg   <= 3'h0;
						tx_state_reg <= uart_pkg::LN_DATA;
					end
				end
				uart_pkg::LN_DATA: begin
					if (tx_os_reg == uart_pkg::OS_LAST) begin
						tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
						tx_idx_reg <= tx_idx_reg + 3'h1;
						tx_bit_reg <= (tx_idx_reg == 3'h7) ? 1'b1 : tx_sh_reg[1];
						if (tx_idx_reg == 3'h7) begin
							tx_state_reg <= uart_pkg::LN_STOP;
						end
					end
				end
				uart_pkg::LN_STOP: begin
					if (tx_os_reg == uart_pkg::OS_LAST) begin
						tx_state_reg <= uart_pkg::LN_IDLE;
					end
				end
				default: tx_state_reg <= uart_pkg::LN_IDLE;
			endcase
		end
	end

	// The infrared strap is a live pin, so this flop has no asynchronous reset and follows it while reset is held.
	// Reset forces the mark level here directly, since the bit register may not have settled on the first edge.
	always_ff @(posedge ref_clk) begin
		tx_out <= (sys_rst ? 1'b1 : tx_bit_reg) ^ infrared_enable_pin;
	end

	wire tx_load    = tick && tx_idle && thr_full_reg;
	wire tx_flush   = wr_fcr && bus_wdata[uart_pkg::FCR_TX_FLUSH];

	// Control and configuration registers.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ier_reg    <= uart_pkg::RST_ZERO;
			fcr_reg    <= uart_pkg::RST_ZERO;
			lcr_reg    <= uart_pkg::RST_ZERO;
			mcr_reg    <= uart_pkg::RST_ZERO;
			feature_control_reg   <= uart_pkg::RST_ZERO;
			efr_reg    <= uart_pkg::RST_ZERO;
			tx_trigger_level_reg  <= uart_pkg::RST_ZERO;
			trig_reg   <= uart_pkg::RST_ZERO;
			scr_reg    <= uart_pkg::RST_SCR;
			dll_reg    <= uart_pkg::RST_ZERO;
			dlm_reg    <= uart_pkg::RST_ZERO;
			thr_reg    <= uart_pkg::RST_ZERO;
			eeprom_reg <= 3'h0;
		end else if (wr) begin
			if (wr_ier) ier_reg <= bus_wdata;
			if (wr_fcr) fcr_reg <= bus_wdata;
			if (wr_dll) dll_reg <= bus_wdata;
			if (wr_dlm) dlm_reg <= bus_wdata;
			if (wr_thr) thr_reg <= bus_wdata;
			if (hit(bus_addr, uart_pkg::ADDR_LCR)) lcr_reg <= bus_wdata;
			if (hit(bus_addr, uart_pkg::ADDR_MCR)) mcr_reg <= bus_wdata;
			if (hit(bus_addr, uart_pkg::ADDR_SCR)) scr_reg <= bus_wdata;
			if (hit(bus_addr, uart_pkg::ADDR_FEATURE_CONTROL)) feature_control_reg <= bus_wdata;
			if (hit(bus_addr, uart_pkg::ADDR_EFR)) efr_reg <= bus_wdata;
			if (hit(bus_addr, uart_pkg::ADDR_TXLVL)) tx_trigger_level_reg <= bus_wdata;
			if (hit(bus_addr, uart_pkg::ADDR_EEPROM)) eeprom_reg <= bus_wdata[2:0];
			// Values above 0x40 are held at 0x40, the largest legal level.
			if (wr_trig) trig_reg <= (bus_wdata > uart_pkg::TRIG_MAX) ? uart_pkg::TRIG_MAX : bus_wdata;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_flow
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					flow_reg[gi] <= uart_pkg::RST_ZERO;
				end else if (wr && hit(bus_addr, uart_pkg::ADDR_FLOW + 10'(gi))) begin
					flow_reg[gi] <= bus_wdata;
				end
			end
		end
	endgenerate

	// Hardware-set flags: the set wins over a clear in the same cycle.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			thr_full_reg <= 1'b0;
			overrun_reg  <= 1'b0;
			delta_reg    <= 4'h0;
			isr_reg      <= uart_pkg::RST_ISR;
			irq_reg      <= 1'b0;
		end else if (clk_en) begin
			thr_full_reg <= wr_thr || (thr_full_reg && !tx_load && !tx_flush);
			overrun_reg  <= (rx_push && !fifo_in_ready) || (overrun_reg && !rd_lsr);
			delta_reg    <= (modem_now ^ modem_prev) | (rd_msr ? 4'h0 : delta_reg);
			isr_reg      <= isr_next;
			irq_reg      <= !isr_next[0];
		end
	end

	// Previous modem levels carry no reset so no false delta appears after release.
	always_ff @(posedge ref_clk) begin
		if (clk_en) begin
			modem_prev <= modem_now;
		end
	end

	// Identifier read arms window unloading; any access other than a window read disarms it.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			armed_reg <= 1'b0;
		end else if (acc) begin
			armed_reg <= (rd && is_ident) || (armed_reg && is_window && !bus_wr);
		end
	end

	// Read data mux.
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = 16'h0000;
		case (bus_addr)
			uart_pkg::ADDR_HOLD:     rd_mux = {8'h00, dlab ? dll_reg : fifo_head[7:0]};
			uart_pkg::ADDR_IER:      rd_mux = {8'h00, dlab ? dlm_reg : ier_reg};
			uart_pkg::ADDR_ISR:      rd_mux = {8'h00, isr_reg};
			uart_pkg::ADDR_LCR:      rd_mux = {8'h00, lcr_reg};
			uart_pkg::ADDR_MCR:      rd_mux = {8'h00, mcr_reg};
			uart_pkg::ADDR_LSR:      rd_mux = {8'h00, lsr_now};
			uart_pkg::ADDR_MSR:      rd_mux = {8'h00, modem_now, delta_reg};
			uart_pkg::ADDR_SCR:      rd_mux = {8'h00, scr_reg};
			uart_pkg::ADDR_FEATURE_CONTROL:     rd_mux = {8'h00, feature_control_reg};
			uart_pkg::ADDR_EFR:      rd_mux = {8'h00, efr_reg};
			uart_pkg::ADDR_TXLVL:    rd_mux = {15'h0000, thr_full_reg};
			uart_pkg::ADDR_RXLVL:    rd_mux = {8'h00, rx_level8};
			uart_pkg::ADDR_GIRQ0:    rd_mux = {15'h0000, irq_reg};
			uart_pkg::ADDR_GIRQ1:    rd_mux = {13'h0000, isr_reg[3:1]};
			uart_pkg::ADDR_IDENT:    rd_mux = {8'h00, uart_pkg::IDENT_VALUE};
			uart_pkg::ADDR_IDENT_DW: rd_mux = {uart_pkg::IDENT_VALUE, 8'h00};
			uart_pkg::ADDR_EEPROM:   rd_mux = {13'h0000, eeprom_reg};
			// Status rides in the upper byte; a disarmed read peeks without popping.
			uart_pkg::ADDR_WINDOW:   rd_mux = {lsr_now, fifo_out_valid ? fifo_head[7:0] : 8'h00};
			default: begin
				if (bus_addr >= uart_pkg::ADDR_FLOW && bus_addr < uart_pkg::ADDR_FLOW + 10'h004) begin
					rd_mux = {8'h00, flow_reg[bus_addr[1:0]]};
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_reg  <= 16'h0000;
			rvalid_reg <= 1'b0;
		end else if (clk_en) begin
			rvalid_reg <= bus_rd;
			if (bus_rd) rdata_reg <= rd_mux;
		end
	end

	// Pins.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rts_n_out         <= 1'b1;
			dtr_n_out         <= 1'b1;
			eeprom_clock_out  <= 1'b0;
			eeprom_select_out <= 1'b0;
			eeprom_data_out   <= 1'b0;
		end else if (clk_en) begin
			rts_n_out         <= !mcr_reg[1];
			dtr_n_out         <= !mcr_reg[0];
			eeprom_clock_out  <= eeprom_reg[0];
			eeprom_select_out <= eeprom_reg[1];
			eeprom_data_out   <= eeprom_reg[2];
		end
	end

	assign bus_rdata  = rdata_reg;
	assign bus_rvalid = rvalid_reg;
	assign irq_out    = irq_reg;

	// Checks.
	sequence s_ident_rd;
		clk_en && bus_rd && is_ident;
	endsequence
	sequence s_win_rd;
		clk_en && bus_rd && is_window && !bus_wr;
	endsequence

	property p_trig_clamp;
		@(posedge ref_clk) disable iff (sys_rst) wr_trig && bus_wdata > 8'h40 |=> trig_reg == 8'h40;
	endproperty
	a_trig_clamp: assert property (p_trig_clamp) else $error("trigger not clamped");

	property p_rx_irq;
		@(posedge ref_clk) disable iff (sys_rst) clk_en && rx_at_trig && ier_reg[0] && !line_irq |=> isr_reg == uart_pkg::ISR_RX && irq_out;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("receive interrupt missing");

	property p_reset_vals;
		@(posedge ref_clk) disable iff (1'b0) sys_rst |=> ier_reg == 8'h00 && isr_reg == 8'h01 && lsr_now == 8'h60 && scr_reg == 8'hff && trig_reg == 8'h00;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("wrong reset value");

	property p_msr_reset;
		@(posedge ref_clk) disable iff (1'b0) sys_rst |=> delta_reg == 4'h0;
	endproperty
	a_msr_reset: assert property (p_msr_reset) else $error("modem deltas not cleared");

	property p_tx_idle;
		@(posedge ref_clk) disable iff (1'b0) sys_rst |=> tx_out == !$past(infrared_enable_pin);
	endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("transmit idle level wrong");

	property p_ident;
		@(posedge ref_clk) disable iff (sys_rst) s_ident_rd |=> armed_reg && bus_rvalid && (bus_rdata == 16'h005a || bus_rdata == 16'h5a00);
	endproperty
	a_ident: assert property (p_ident) else $error("identifier read wrong");

	property p_disarm;
		@(posedge ref_clk) disable iff (sys_rst) acc && !is_ident && !is_window |=> !armed_reg;
	endproperty
	a_disarm: assert property (p_disarm) else $error("other access left window armed");

	property p_window;
		@(posedge ref_clk) disable iff (sys_rst) s_win_rd |=> bus_rdata[8] == $past(fifo_out_valid);
	endproperty
	a_window: assert property (p_window) else $error("empty window shows data");

	property p_global;
		@(posedge ref_clk) disable iff (sys_rst) clk_en && bus_rd && bus_addr == 10'h080 |=> bus_rdata[0] == $past(irq_out);
	endproperty
	a_global: assert property (p_global) else $error("global interrupt register wrong");

	property p_pins;
		@(posedge ref_clk) disable iff (1'b0) sys_rst |=> rts_n_out && dtr_n_out && !eeprom_clock_out && !eeprom_select_out && !eeprom_data_out;
	endproperty
	a_pins: assert property (p_pins) else $error("pin reset level wrong");
endmodule

/* File: logic/uart_pkg.sv */
// Notes on behaviour
// - Receive trigger write sets level, 0x00 to 0x40.
// - Receive interrupt when FIFO level reaches trigger.
// - Channel registers take documented values on reset.
// - Modem status deltas clear; upper bits follow inputs.
// - Transmit idles high, or low in infrared mode.
// - Identifier readable at 0x8D, or 0x8C aligned.
// - Window reads stay ordered until another access.
// - Window returns byte plus status; bit8 low means empty.
// - Global interrupt registers at 0x080 through 0x083.
package uart_pkg;
	localparam logic [9:0] ADDR_HOLD     = 10'h000;
	localparam logic [9:0] ADDR_IER      = 10'h001;
	localparam logic [9:0] ADDR_ISR      = 10'h002;
	localparam logic [9:0] ADDR_LCR      = 10'h003;
	localparam logic [9:0] ADDR_MCR      = 10'h004;
	localparam logic [9:0] ADDR_LSR      = 10'h005;
	localparam logic [9:0] ADDR_MSR      = 10'h006;
	localparam logic [9:0] ADDR_SCR      = 10'h007;
	localparam logic [9:0] ADDR_FEATURE_CONTROL     = 10'h008;
	localparam logic [9:0] ADDR_EFR      = 10'h009;
	localparam logic [9:0] ADDR_TXLVL    = 10'h00a;
	localparam logic [9:0] ADDR_RXLVL    = 10'h00b;
	localparam logic [9:0] ADDR_FLOW_CHAR_STATUS    = 10'h00c;
	localparam logic [9:0] ADDR_FLOW     = 10'h010;
	localparam logic [9:0] ADDR_GIRQ0    = 10'h080;
	localparam logic [9:0] ADDR_GIRQ1    = 10'h081;
	localparam logic [9:0] ADDR_GIRQ2    = 10'h082;
	localparam logic [9:0] ADDR_GIRQ3    = 10'h083;
	localparam logic [9:0] ADDR_IDENT_DW = 10'h08c;
	localparam logic [9:0] ADDR_IDENT    = 10'h08d;
	localparam logic [9:0] ADDR_EEPROM   = 10'h08e;
	localparam logic [9:0] ADDR_WINDOW   = 10'h180;
	// Identifier value is arbitrary.
	localparam logic [7:0] IDENT_VALUE   = 8'h5a;
	localparam logic [7:0] RST_ZERO      = 8'h00;
	localparam logic [7:0] RST_ISR       = 8'h01;
	localparam logic [7:0] RST_LSR       = 8'h60;
	localparam logic [7:0] RST_SCR       = 8'hff;
	localparam logic [7:0] TRIG_MAX      = 8'h40;
	localparam logic [7:0] ISR_LINE      = 8'h06;
	localparam logic [7:0] ISR_RX        = 8'h04;
	localparam logic [7:0] ISR_TX        = 8'h02;
	localparam logic [7:0] ISR_MODEM     = 8'h00;
	localparam int         LCR_DLAB      = 7;
	localparam int         FCR_RX_FLUSH  = 1;
	localparam int         FCR_TX_FLUSH  = 2;
	localparam int         FIFO_DEPTH    = 16;
	localparam int         FIFO_WIDTH    = 10;
	localparam logic [3:0] OS_MID        = 4'h7;
	localparam logic [3:0] OS_LAST       = 4'hf;
	typedef enum logic [1:0] {
		LN_IDLE  = 2'b00,
		LN_START = 2'b01,
		LN_DATA  = 2'b10,
		LN_STOP  = 2'b11
	} line_state_t;
endpackage
